// file: ptb_tlb.v
// paged translation buffer: 32-entry fully associative tlb with lru refill,
// purge registers on an avalon-mm slave and a request port to a table walker.
// assumes one 250 mhz clock, inputs synchronous to it, and an external walker
// that fetches both table levels, sets the used bits and reports the result.
//
// Overview of operation
// - thirty-two associative entries; a hit translates in one clock
// - software cannot read or write entries; only purges and table base writes remove them
// - fill only when both levels valid and the access is permitted
// - fill target picked by least-recently-used hardware, no software
// - fill writes the tag with 20-bit page number and space bit
// - fill loads the 20-bit frame from the second-level entry
// - fill copies cache-inhibit and dirty from the second-level entry
// - fill stores the most restrictive of both privilege levels
// - each entry has full/empty state plus replacement state
// - compare page and space against all full entries in parallel
// - permitted hit with no dirty update gives the frame next cycle
// - hit forbidden by privilege raises abort, no physical address
// - miss, or write hit with clean entry, starts a table walk
// - a filling walk must set both levels' used bits in memory
// - entries hold no valid or used flags
// - write to a purge register invalidates the matching entry
// - table base write invalidates all entries of that space only
// - changing translation enables leaves entries untouched
// - each 32-bit address becomes a 32-bit physical one or an error
// - translation disabled for a mode passes its addresses unchanged
// - dual map gives user and supervisor separate spaces, else one
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/100ps
`include "ptb_defs.vh"

module ptb_tlb (
  // clock and reset
  input  wire        clock,
  input  wire        rst,
  // avalon-mm register slave
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // translation requests from the cpu
  input  wire        xl_req,
  input  wire [31:0] xl_vaddr,
  input  wire        xl_user,
  input  wire        xl_write,
  output reg         xl_busy_q,
  output reg         xl_done_q,
  output reg  [31:0] xl_paddr_q,
  output reg         xl_abort_q,
  output reg         xl_cache_inhibit_q,
  // table walker
  output reg         walk_req_q,
  output reg  [31:0] walk_vaddr_q,
  output reg  [19:0] walk_table_base_q,
  output reg         walk_write_q,
  output reg         walk_mark_used_q,
  input  wire        walk_done,
  input  wire        walk_l1_valid,
  input  wire        walk_l2_valid,
  input  wire [1:0]  walk_l1_pl,
  input  wire [1:0]  walk_l2_pl,
  input  wire [19:0] walk_frame_number,
  input  wire        walk_cache_inhibit,
  input  wire        walk_dirty
);

  ////////////////////////////////////////////////////////////////////////////
  // entry storage: tag, value, occupancy and age; no valid or used bit here
  reg [`PTB_VPN_W-1:0] tag_vpn_q   [0:`PTB_ENTRIES-1];
  reg                  tag_space_q [0:`PTB_ENTRIES-1];
  reg [1:0]            ent_pl_q    [0:`PTB_ENTRIES-1];
  reg                  ent_dirty_q [0:`PTB_ENTRIES-1];
  reg                  ent_ci_q    [0:`PTB_ENTRIES-1];
  reg [`PTB_PFN_W-1:0] ent_pfn_q   [0:`PTB_ENTRIES-1];
  reg [`PTB_IDX_W-1:0] ent_age_q   [0:`PTB_ENTRIES-1];
  reg [31:0]           ent_full_q;

  // programmable registers and controller state
  reg [19:0]           base0_q;
  reg [19:0]           base1_q;
  reg [2:0]            ctrl_q;
  reg                  state_q;
  reg [`PTB_IDX_W-1:0] target_q;
  reg                  req_space_q;
  reg                  req_user_q;
  reg                  req_write_q;

  // combinational helpers
  wire [31:0]          hit_vec;
  wire [31:0]          purge_vec;
  reg  [`PTB_IDX_W-1:0] hit_idx;
  reg  [`PTB_IDX_W-1:0] victim_idx;
  reg                  found_empty;
  integer              k;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode: a write takes effect only at the edge waitrequest is low
  wire bus_req   = avs_read | avs_write;
  wire bus_wr    = avs_write & ~avs_waitrequest;
  wire wr_base0  = bus_wr & (avs_address == `PTB_REG_BASE0);
  wire wr_base1  = bus_wr & (avs_address == `PTB_REG_BASE1);
  wire wr_purge0 = bus_wr & (avs_address == `PTB_REG_PURGE0);
  wire wr_purge1 = bus_wr & (avs_address == `PTB_REG_PURGE1);
  wire wr_ctrl   = bus_wr & (avs_address == `PTB_REG_CTRL);
  wire purge_sp  = wr_purge1;

  ////////////////////////////////////////////////////////////////////////////
  // space selection and translation enable for the presented request
  wire req_take  = xl_req & ~xl_busy_q & (state_q == `PTB_ST_IDLE);
  wire xlate_on  = xl_user ? ctrl_q[`PTB_CTRL_USER] : ctrl_q[`PTB_CTRL_SUP];
  wire req_space = ctrl_q[`PTB_CTRL_DUAL] & xl_user;
  wire [19:0] req_vpn = xl_vaddr[31:`PTB_OFS_W];

  // privilege check shared by hit path and walk result
  function prot_ok;
    input [1:0] pl;
    input       user;
    input       wr;
    begin
      if (user) begin
        prot_ok = wr ? (pl == `PTB_PL_USR_RW) : (pl >= `PTB_PL_USR_RD);
      end else begin
        prot_ok = wr ? (pl >= `PTB_PL_SUP_RW) : 1'b1;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // per-entry associative compare against page and space
  genvar g;
  generate
    for (g = 0; g < `PTB_ENTRIES; g = g + 1) begin : g_cmp
      assign hit_vec[g]   = ent_full_q[g] & (tag_vpn_q[g] == req_vpn)
                          & (tag_space_q[g] == req_space);
      assign purge_vec[g] = ((wr_purge0 | wr_purge1) & (tag_space_q[g] == purge_sp)
                          & (tag_vpn_q[g] == avs_writedata[31:`PTB_OFS_W]))
                          | (wr_base0 & ~tag_space_q[g])
                          | (wr_base1 & tag_space_q[g]);
    end
  endgenerate

  wire any_hit = |hit_vec;

  // encode hit, and pick victim: lowest empty entry first, else the oldest
  always @* begin
    hit_idx     = {`PTB_IDX_W{1'b0}};
    victim_idx  = {`PTB_IDX_W{1'b0}};
    found_empty = 1'b0;
    for (k = 0; k < `PTB_ENTRIES; k = k + 1) begin
      if (hit_vec[k]) begin
        hit_idx = k[`PTB_IDX_W-1:0];
      end
      if (ent_age_q[k] == `PTB_AGE_MAX && !found_empty) begin
        victim_idx = k[`PTB_IDX_W-1:0];
      end
    end
    for (k = `PTB_ENTRIES - 1; k >= 0; k = k - 1) begin
      if (!ent_full_q[k]) begin
        victim_idx  = k[`PTB_IDX_W-1:0];
        found_empty = 1'b1;
      end
    end
  end

  wire [1:0] hit_pl    = ent_pl_q[hit_idx];
  wire       hit_ok    = prot_ok(hit_pl, xl_user, xl_write);
  wire       hit_clean = xl_write & ~ent_dirty_q[hit_idx];

  ////////////////////////////////////////////////////////////////////////////
  // walk result: net level is the lower, i.e. more restrictive, of the two
  wire [1:0] net_pl  = (walk_l1_pl < walk_l2_pl) ? walk_l1_pl : walk_l2_pl;
  wire       walk_ok = walk_l1_valid & walk_l2_valid
                     & prot_ok(net_pl, req_user_q, req_write_q);
  wire       fill    = (state_q == `PTB_ST_WALK) & walk_done & walk_ok;

  // touch event for lru: permitted hit needing no walk, or fill
  wire       hit_use = req_take & xlate_on & any_hit & hit_ok & ~hit_clean;
  wire       touch   = hit_use | fill;
  wire [`PTB_IDX_W-1:0] touch_idx = fill ? target_q : hit_idx;
  wire [`PTB_IDX_W-1:0] touch_age = ent_age_q[touch_idx];

  ////////////////////////////////////////////////////////////////////////////
  // per-entry update: fill, purge, and age ranking
  generate
    for (g = 0; g < `PTB_ENTRIES; g = g + 1) begin : g_ent
      // reset ranks form a permutation so ages stay unique
      localparam [`PTB_IDX_W-1:0] AGE_INIT = g;
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          ent_full_q[g]  <= 1'b0;
          ent_age_q[g]   <= AGE_INIT;
          tag_vpn_q[g]   <= {`PTB_VPN_W{1'b0}};
          tag_space_q[g] <= 1'b0;
          ent_pl_q[g]    <= 2'h0;
          ent_dirty_q[g] <= 1'b0;
          ent_ci_q[g]    <= 1'b0;
          ent_pfn_q[g]   <= {`PTB_PFN_W{1'b0}};
        end else begin
          // a purge in the fill cycle wins only if it matches the target's old tag or space; the page being filled is not compared
          if (purge_vec[g]) begin
            ent_full_q[g] <= 1'b0;
          end else if (fill && target_q == g) begin
            ent_full_q[g] <= 1'b1;
          end
          if (fill && target_q == g) begin
            tag_vpn_q[g]   <= walk_vaddr_q[31:`PTB_OFS_W];
            tag_space_q[g] <= req_space_q;
            ent_pfn_q[g]   <= walk_frame_number;
            ent_ci_q[g]    <= walk_cache_inhibit;
            ent_dirty_q[g] <= walk_dirty;
            ent_pl_q[g]    <= net_pl;
          end
          // ages stay a permutation; the touched entry becomes age zero
          if (touch) begin
            if (touch_idx == g) begin
              ent_age_q[g] <= {`PTB_IDX_W{1'b0}};
            end else if (ent_age_q[g] < touch_age) begin
              ent_age_q[g] <= ent_age_q[g] + 5'h01;
            end
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // programmable registers; control changes never touch entries
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      base0_q <= `PTB_BASE_RST;
      base1_q <= `PTB_BASE_RST;
      ctrl_q  <= `PTB_CTRL_RST;
    end else begin
      if (wr_base0) begin
        base0_q <= avs_writedata[31:`PTB_OFS_W];
      end
      if (wr_base1) begin
        base1_q <= avs_writedata[31:`PTB_OFS_W];
      end
      if (wr_ctrl) begin
        ctrl_q <= avs_writedata[2:0];
      end
    end
  end

  // slave answer: waitrequest drops for one cycle after a request is seen
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          `PTB_REG_BASE0: avs_readdata <= {base0_q, 12'h000};
          `PTB_REG_BASE1: avs_readdata <= {base1_q, 12'h000};
          `PTB_REG_CTRL:  avs_readdata <= {29'h00000000, ctrl_q};
          `PTB_REG_OCC:   avs_readdata <= ent_full_q;
          default:        avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // translation controller
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q            <= `PTB_ST_IDLE;
      xl_busy_q          <= 1'b0;
      xl_done_q          <= 1'b0;
      xl_abort_q         <= 1'b0;
      xl_paddr_q         <= 32'h00000000;
      xl_cache_inhibit_q <= 1'b0;
      walk_req_q         <= 1'b0;
      walk_vaddr_q       <= 32'h00000000;
      walk_table_base_q  <= 20'h00000;
      walk_write_q       <= 1'b0;
      walk_mark_used_q   <= 1'b0;
      target_q           <= {`PTB_IDX_W{1'b0}};
      req_space_q        <= 1'b0;
      req_user_q         <= 1'b0;
      req_write_q        <= 1'b0;
    end else begin
      xl_done_q  <= 1'b0;
      xl_abort_q <= 1'b0;
      case (state_q)
        `PTB_ST_IDLE: begin
          if (req_take) begin
            if (!xlate_on) begin
              xl_done_q          <= 1'b1;
              xl_paddr_q         <= xl_vaddr;
              xl_cache_inhibit_q <= 1'b0;
            end else if (any_hit && !hit_ok) begin
              xl_done_q  <= 1'b1;
              xl_abort_q <= 1'b1;
            end else if (any_hit && !hit_clean) begin
              xl_done_q          <= 1'b1;
              xl_paddr_q         <= {ent_pfn_q[hit_idx], xl_vaddr[11:0]};
              xl_cache_inhibit_q <= ent_ci_q[hit_idx];
            end else begin
              // a clean write hit refills its own entry, avoiding duplicates
              state_q           <= `PTB_ST_WALK;
              xl_busy_q         <= 1'b1;
              walk_req_q        <= 1'b1;
              walk_vaddr_q      <= xl_vaddr;
              walk_table_base_q <= req_space ? base1_q : base0_q;
              walk_write_q      <= xl_write;
              walk_mark_used_q  <= 1'b1;
              target_q          <= any_hit ? hit_idx : victim_idx;
              req_space_q       <= req_space;
              req_user_q        <= xl_user;
              req_write_q       <= xl_write;
            end
          end
        end
        `PTB_ST_WALK: begin
          if (walk_done) begin
            state_q          <= `PTB_ST_IDLE;
            xl_busy_q        <= 1'b0;
            walk_req_q       <= 1'b0;
            walk_mark_used_q <= 1'b0;
            xl_done_q        <= 1'b1;
            if (walk_ok) begin
              xl_paddr_q         <= {walk_frame_number, walk_vaddr_q[11:0]};
              xl_cache_inhibit_q <= walk_cache_inhibit;
            end else begin
              xl_abort_q <= 1'b1;
            end
          end
        end
        default: begin
          state_q <= `PTB_ST_IDLE;
        end
      endcase
    end
  end

endmodule

// file: ptb_defs.vh
// constants for the paged translation buffer: register map, field positions,
// reset values and entry geometry; included by the buffer module only
`ifndef PTB_DEFS_VH
`define PTB_DEFS_VH

// entry geometry
`define PTB_ENTRIES      32
`define PTB_IDX_W        5
`define PTB_VPN_W        20
`define PTB_PFN_W        20
`define PTB_OFS_W        12
`define PTB_AGE_MAX      5'h1F

// register byte offsets on the avalon slave
`define PTB_ADDR_W       5
`define PTB_REG_BASE0    5'h00
`define PTB_REG_BASE1    5'h04
`define PTB_REG_PURGE0   5'h08
`define PTB_REG_PURGE1   5'h0C
`define PTB_REG_CTRL     5'h10
`define PTB_REG_OCC      5'h14

// unit_control_word fields
`define PTB_CTRL_USER    0
`define PTB_CTRL_SUP     1
`define PTB_CTRL_DUAL    2
`define PTB_CTRL_RST     3'h0
`define PTB_BASE_RST     20'h00000

// privilege levels: 00 sup read, 01 sup rw, 10 user read, 11 user rw
`define PTB_PL_SUP_RW    2'h1
`define PTB_PL_USR_RD    2'h2
`define PTB_PL_USR_RW    2'h3

// controller states
`define PTB_ST_IDLE      1'h0
`define PTB_ST_WALK      1'h1

`endif

// file: ptb_tlb_monitor.sv
// checker for the translation buffer ports
// assumes it is bound into ptb_tlb with one clock domain
`timescale 1ns/100ps
module ptb_tlb_monitor (
  // clock and reset
  input wire        clock,
  input wire        rst,
  // cpu side
  input wire        xl_req,
  input wire        xl_busy_q,
  input wire        xl_done_q,
  input wire [31:0] xl_paddr_q,
  input wire        xl_abort_q,
  input wire        xl_cache_inhibit_q,
  // walker side
  input wire        walk_req_q,
  input wire [31:0] walk_vaddr_q,
  input wire        walk_mark_used_q,
  input wire        walk_done,
  input wire        walk_l1_valid,
  input wire        walk_l2_valid,
  input wire [19:0] walk_frame_number,
  input wire        walk_cache_inhibit
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////////////
  // answer timing and walk handshake
  property p_answer; xl_req && !xl_busy_q |=> xl_done_q || (xl_busy_q && walk_req_q); endproperty
  property p_used; $rose(walk_req_q) |-> walk_mark_used_q && xl_busy_q; endproperty
  property p_hold; walk_req_q && !walk_done |=> walk_req_q && $stable(walk_vaddr_q); endproperty
  property p_end; walk_req_q && walk_done |=> !walk_req_q && !xl_busy_q && xl_done_q; endproperty
  property p_invalid; walk_req_q && walk_done && !(walk_l1_valid && walk_l2_valid) |=> xl_abort_q; endproperty
  property p_frame; walk_req_q && walk_done |=> xl_abort_q || xl_paddr_q[31:12] == $past(walk_frame_number);
  endproperty
  property p_ci; walk_req_q && walk_done |=> xl_abort_q || xl_cache_inhibit_q == $past(walk_cache_inhibit);
  endproperty
  property p_abort; xl_abort_q |-> xl_done_q; endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered");
  a_used: assert property (p_used)
    else $error("walk without used marking");
  a_hold: assert property (p_hold)
    else $error("walk request moved");
  a_end: assert property (p_end)
    else $error("walk end not answered");
  a_invalid: assert property (p_invalid)
    else $error("invalid mapping not aborted");
  a_frame: assert property (p_frame)
    else $error("fill frame wrong");
  a_ci: assert property (p_ci)
    else $error("fill inhibit wrong");
  a_abort: assert property (p_abort)
    else $error("abort outside answer");
  // main scenarios reached
  c_hit: cover property (xl_req && !xl_busy_q ##1 xl_done_q && !xl_abort_q);
  c_abort: cover property (xl_abort_q);
  c_fill: cover property (walk_done ##1 !xl_abort_q);
endmodule
bind ptb_tlb ptb_tlb_monitor u_mon (
  .clock, .rst, .xl_req, .xl_busy_q, .xl_done_q, .xl_paddr_q, .xl_abort_q, .xl_cache_inhibit_q,
  .walk_req_q, .walk_vaddr_q, .walk_mark_used_q, .walk_done, .walk_l1_valid, .walk_l2_valid,
  .walk_frame_number, .walk_cache_inhibit
);

// file: ptb_walk_model.sv
// table walker model: answers each walk from a flat page map
// assumes walk_req_q stays high until walk_done
`timescale 1ns/100ps
module ptb_walk_model #(
  parameter [19:0] KEY = 20'hA5A5A
) (
  // clock and reset
  input  wire        clock,
  input  wire        rst,
  // request from the buffer
  input  wire        walk_req_q,
  input  wire [31:0] walk_vaddr_q,
  input  wire        walk_write_q,
  input  wire        walk_mark_used_q,
  // result to the buffer
  output reg         walk_done,
  output wire        walk_l1_valid,
  output wire        walk_l2_valid,
  output wire [1:0]  walk_l1_pl,
  output wire [1:0]  walk_l2_pl,
  output wire [19:0] walk_frame_number,
  output wire        walk_cache_inhibit,
  output wire        walk_dirty
);
  // knobs set by the bench between translations
  reg     [3:0]  dly = 4'h2;
  reg            l1v = 1'h1;
  reg            l2v = 1'h1;
  reg     [1:0]  l1pl = 2'h3;
  reg     [1:0]  l2pl = 2'h3;
  reg            ci = 1'h0;
  reg     [3:0]  cnt_q;
  reg     [27:0] res_q;
  integer        walks = 0;
  integer        used_sets = 0;
  //////////////////////////////////////////////////////////////////////////////
  // inverted outside the done cycle so a stale result never looks good
  assign {walk_l1_valid, walk_l2_valid, walk_l1_pl, walk_l2_pl, walk_cache_inhibit, walk_dirty,
          walk_frame_number} = walk_done ? res_q : ~res_q;
  // one lookup per request, dly+1 cycles long
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q     <= 4'h0;
      walk_done <= 1'h0;
      res_q     <= 28'h0;
    end else begin
      walk_done <= 1'h0;
      cnt_q     <= 4'h0;
      if (walk_req_q && !walk_done) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q >= dly) begin
          walk_done <= 1'h1;
          // dirty as left after a write sets it
          res_q     <= {l1v, l2v, l1pl, l2pl, ci, walk_write_q, walk_vaddr_q[31:12] ^ KEY};
          walks     <= walks + 1;
          if (walk_mark_used_q)
            used_sets <= used_sets + 1;
        end
      end
    end
  end
endmodule

// file: ptb_tlb_tb.sv
// bench for ptb_tlb: avalon register access and translation sequences
// assumes the walker model answers every walk request
`timescale 1ns/100ps
module ptb_tlb_tb;
  localparam [19:0] KEY = 20'hA5A5A;
  reg         clock = 1'h0, rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0;
  reg         xl_req = 1'h0, xl_user = 1'h0, xl_write = 1'h0, ab, ci;
  reg  [4:0]  avs_address = 5'h00;
  reg  [31:0] avs_writedata = 32'h0, xl_vaddr = 32'h0, rd, pa;
  wire [31:0] avs_readdata, xl_paddr_q, walk_vaddr_q;
  wire        avs_waitrequest, xl_busy_q, xl_done_q, xl_abort_q, xl_cache_inhibit_q, walk_req_q;
  wire        walk_write_q, walk_mark_used_q, walk_done, walk_l1_valid, walk_l2_valid;
  wire        walk_cache_inhibit, walk_dirty;
  wire [1:0]  walk_l1_pl, walk_l2_pl;
  wire [19:0] walk_table_base_q, walk_frame_number;
  integer     failures = 0, checks = 0, w0, i;
  //////////////////////////////////////////////////////////////////////////////
  ptb_tlb u_dut (
    .clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .xl_req, .xl_vaddr, .xl_user, .xl_write, .xl_busy_q, .xl_done_q, .xl_paddr_q, .xl_abort_q,
    .xl_cache_inhibit_q, .walk_req_q, .walk_vaddr_q, .walk_table_base_q, .walk_write_q, .walk_mark_used_q,
    .walk_done, .walk_l1_valid, .walk_l2_valid, .walk_l1_pl, .walk_l2_pl, .walk_frame_number,
    .walk_cache_inhibit, .walk_dirty);
  ptb_walk_model #(.KEY(KEY)) u_walk (
    .clock, .rst, .walk_req_q, .walk_vaddr_q, .walk_write_q, .walk_mark_used_q, .walk_done,
    .walk_l1_valid, .walk_l2_valid, .walk_l1_pl, .walk_l2_pl, .walk_frame_number,
    .walk_cache_inhibit, .walk_dirty);
  // 250 mhz
  always #2 clock = ~clock;
  //////////////////////////////////////////////////////////////////////////////
  task close_out;
    begin
      if (failures == 0 && checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask
  // one access, held until waitrequest is sampled low
  task bus(input w, input [4:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clock);
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= !w;
      avs_write     <= w;
      n = 0;
      @(posedge clock);
      while (avs_waitrequest && n < 50) begin
        @(posedge clock);
        n = n + 1;
      end
      if (n >= 50)
        failures = failures + 1;
      rd = avs_readdata;
      avs_read  <= 1'h0;
      avs_write <= 1'h0;
    end
  endtask
  task rc(input [4:0] a, input [31:0] e);
    begin
      bus(1'h0, a, 32'h0);
      chk(rd, e);
    end
  endtask
  // one translation; results kept from the done cycle
  task xl(input [31:0] va, input u, input w);
    integer n;
    begin
      @(posedge clock);
      xl_vaddr <= va;
      xl_user  <= u;
      xl_write <= w;
      xl_req   <= 1'h1;
      @(posedge clock);
      xl_req <= 1'h0;
      #1;
      n = 0;
      while (xl_done_q !== 1'h1 && n < 100) begin
        @(posedge clock);
        #1;
        n = n + 1;
      end
      if (n >= 100)
        failures = failures + 1;
      pa = xl_paddr_q;
      ab = xl_abort_q;
      ci = xl_cache_inhibit_q;
    end
  endtask
  // pt: passthrough expected; ew: walks expected
  task tr(input [31:0] va, input u, input w, input pt, input eab, input integer ew);
    begin
      w0 = u_walk.walks;
      xl(va, u, w);
      chk(ab, eab);
      if (!eab)
        chk(pa, pt ? va : {va[31:12] ^ KEY, va[11:0]});
      chk(u_walk.walks - w0, ew);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'h0;
    for (i = 0; i < 7; i = i + 1)
      rc({i[2:0], 2'h0}, 32'h0);
    tr(32'h1234_5678, 1'h1, 1'h0, 1'h1, 1'h0, 0);
    bus(1'h1, 5'h10, 32'h3);
    tr(32'h0004_1000, 1'h1, 1'h0, 1'h0, 1'h0, 1);
    tr(32'h0004_1ABC, 1'h1, 1'h0, 1'h0, 1'h0, 0);
    rc(5'h14, 32'h1);
    bus(1'h1, 5'h10, 32'h0);
    tr(32'h0004_1000, 1'h1, 1'h0, 1'h1, 1'h0, 0);
    bus(1'h1, 5'h10, 32'h3);
    tr(32'h0004_1000, 1'h1, 1'h0, 1'h0, 1'h0, 0);
    bus(1'h1, 5'h08, 32'h0004_1000);
    rc(5'h14, 32'h0);
    u_walk.l2pl = 2'h0;
    u_walk.dly = 4'h7;
    tr(32'h0009_2000, 1'h1, 1'h0, 1'h0, 1'h1, 1);
    tr(32'h0009_2000, 1'h0, 1'h0, 1'h0, 1'h0, 1);
    tr(32'h0009_2000, 1'h1, 1'h0, 1'h0, 1'h1, 0);
    u_walk.l2pl = 2'h3;
    u_walk.l1v = 1'h0;
    u_walk.dly = 4'h0;
    tr(32'h000A_3000, 1'h0, 1'h0, 1'h0, 1'h1, 1);
    rc(5'h14, 32'h1);
    u_walk.l1v = 1'h1;
    u_walk.ci = 1'h1;
    tr(32'h000B_4000, 1'h0, 1'h0, 1'h0, 1'h0, 1);
    chk(ci, 1'h1);
    u_walk.ci = 1'h0;
    tr(32'h000B_4000, 1'h0, 1'h1, 1'h0, 1'h0, 1);
    chk(ci, 1'h0);
    tr(32'h000B_4000, 1'h0, 1'h1, 1'h0, 1'h0, 0);
    bus(1'h1, 5'h00, 32'h0);
    rc(5'h14, 32'h0);
    bus(1'h1, 5'h10, 32'h7);
    tr(32'h000C_5000, 1'h1, 1'h0, 1'h0, 1'h0, 1);
    tr(32'h000C_5000, 1'h0, 1'h0, 1'h0, 1'h0, 1);
    bus(1'h1, 5'h04, 32'h0);
    rc(5'h14, 32'h2);
    tr(32'h000C_5000, 1'h0, 1'h0, 1'h0, 1'h0, 0);
    tr(32'h000C_5000, 1'h1, 1'h0, 1'h0, 1'h0, 1);
    bus(1'h1, 5'h10, 32'h3);
    bus(1'h1, 5'h04, 32'h0);
    bus(1'h1, 5'h00, 32'h0);
    for (i = 0; i < 32; i = i + 1)
      tr(i << 12, 1'h0, 1'h0, 1'h0, 1'h0, 1);
    rc(5'h14, 32'hFFFF_FFFF);
    tr(32'h0, 1'h0, 1'h0, 1'h0, 1'h0, 0);
    tr(32'h0002_0000, 1'h0, 1'h0, 1'h0, 1'h0, 1);
    tr(32'h0, 1'h0, 1'h0, 1'h0, 1'h0, 0);
    tr(32'h0000_1000, 1'h0, 1'h0, 1'h0, 1'h0, 1);
    bus(1'h1, 5'h14, 32'h0);
    rc(5'h14, 32'hFFFF_FFFF);
    chk(u_walk.used_sets, u_walk.walks);
    close_out;
  end
  // hang guard, far past the ~300 cycles needed
  initial begin
    #100000;
    failures = failures + 1;
    close_out;
  end
endmodule
